/* File: common/usb_otg_csr_pkg.sv */
// Purpose: Shared constants and types of the USB OTG register bank
// Assumes: 32-bit AHB-Lite slave, word registers on aligned addresses
// Notes: Tables are indexed by the bank's own register index
package usb_otg_csr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register table sizes
  localparam int NUM_REGS = 47;
  localparam int IDX_W = 6;
  localparam int OFF_W = 12;

  // Byte offsets of the listed registers, by index
  localparam logic [11:0] REG_OFFSET [NUM_REGS] = '{
    12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
    12'h020, 12'h024, 12'h028, 12'h02C, 12'h038, 12'h03C, 12'h100, 12'h104,
    12'h108, 12'h10C, 12'h400, 12'h404, 12'h408, 12'h410, 12'h414, 12'h418,
    12'h440, 12'h500, 12'h508, 12'h50C, 12'h510, 12'h800, 12'h804, 12'h808,
    12'h810, 12'h814, 12'h818, 12'h81C, 12'h834, 12'h900, 12'h908, 12'h910,
    12'h918, 12'hB00, 12'hB08, 12'hB10, 12'hD0C, 12'hE00, 12'hE10};

  // Reset values, by index
  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'h00010000, 32'h00000000, 32'h00000000, 32'h00001400, 32'h20000000,
    32'h04000020, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000200,
    32'h02000200, 32'h00080200, 32'h00000000, 32'h00001000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h0000EA60,
    32'h00003FFF, 32'h00080100, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h02200000,
    32'h00000000, 32'h00000010, 32'h00000000, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00000080, 32'h00000000,
    32'h00000200, 32'h00008000, 32'h00000080, 32'h00000000, 32'h00000000,
    32'h00000000, 32'h00000000};

  // Write behaviour codes
  localparam logic [1:0] ACC_RW = 2'h0;
  localparam logic [1:0] ACC_RO = 2'h1;
  localparam logic [1:0] ACC_W1C = 2'h2;
  localparam logic [1:0] ACC_RC = 2'h3;

  // Write behaviour, by index
  localparam logic [1:0] REG_ACCESS [NUM_REGS] = '{
    2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 2'h1,
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0,
    2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};

  ////////////////////////////////////////////////////////////////////////
  // Named indices used by the logic
  localparam logic [5:0] IDX_OTG_CTRL = 6'h00;
  localparam logic [5:0] IDX_BUS_CFG = 6'h02;
  localparam logic [5:0] IDX_LINK_CFG = 6'h03;
  localparam logic [5:0] IDX_INT_STS = 6'h05;
  localparam logic [5:0] IDX_INT_MSK = 6'h06;
  localparam logic [5:0] IDX_PORT_CTRL = 6'h18;
  localparam logic [5:0] IDX_CH0_CHAR = 6'h19;
  localparam logic [5:0] IDX_PWR_CLK = 6'h2D;

  // Mode group address ranges and the FIFO window
  localparam logic [11:0] HOST_LO = 12'h400;
  localparam logic [11:0] HOST_HI = 12'h7FF;
  localparam logic [11:0] DEV_LO = 12'h800;
  localparam logic [11:0] DEV_HI = 12'hDFF;
  localparam int FIFO_SEL_BIT = 12;

  // Field positions
  localparam int ROLE_BIT = 21;
  localparam int CONN_ID_BIT = 16;
  localparam int STS_ROLE_BIT = 0;
  localparam int MISMATCH_BIT = 1;
  localparam int GLB_INT_BIT = 0;
  localparam int FORCE_HOST_BIT = 29;
  localparam int FORCE_DEV_BIT = 30;
  localparam int CH_DIR_IN_BIT = 15;

  // AHB codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Decoded request held over the data phase
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic hit;
    logic illegal;
    logic fifo_ok;
    logic [5:0] idx;
  } ahb_req_type;

endpackage

/* File: src/usb_otg_csr_map.sv */
// Purpose: Control and status register bank of a USB OTG controller
// Assumes: AHB-Lite slave on sys_clk_in, one wait state on every write
// Notes: Field behaviour, FIFO storage and protocol engine live elsewhere
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - Word registers on aligned AHB slave addresses
// R2 - Master uses only full word transfers
// R3 - Global, power, FIFO, port registers always active
// R4 - Software avoids inactive mode register group
// R5 - Inactive group access sets mismatch flag, interrupt
// R6 - Software reprograms new mode group after switch
// R7 - IN channel FIFO read only, OUT write only
// R8 - One clock domain, disjoint host/device ranges
// R9 - Single power and clock gating register
// R10 - Read-only role bit: 1 host, 0 device
// R11 - Unmapped reads zero, writes ignored
// R12 - Reset loads every documented reset value
module usb_otg_csr_map #(
  parameter int ADDR_W = 13  // Byte address width of the slave window
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic conn_id_in,
  output logic current_role_out,
  output logic mode_mismatch_irq_out,
  output logic [31:0] power_clock_gating_out,
  output logic fifo_rd_out,
  input wire logic [31:0] fifo_rdata_in,
  output logic fifo_wr_out,
  output logic [31:0] fifo_wdata_out
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (ADDR_W < 13) begin : g_addr_check
    $error("ADDR_W must cover the register and FIFO windows");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Register index of an offset, miss flagged in the top bit
  function automatic logic [6:0] find_index(input logic [11:0] off);
    logic [6:0] res;
    res = 7'h40;
    for (int k = 0; k < usb_otg_csr_pkg::NUM_REGS; k++) begin
      if (usb_otg_csr_pkg::REG_OFFSET[k] == {off[11:2], 2'h0}) begin
        res = {1'b0, 6'(k)};
      end
    end
    return res;
  endfunction

  // Host group, the port register excepted
  function automatic logic in_host_group(input logic [11:0] off);
    return (off >= usb_otg_csr_pkg::HOST_LO) && (off <= usb_otg_csr_pkg::HOST_HI) &&
      ({off[11:2], 2'h0} != usb_otg_csr_pkg::REG_OFFSET[usb_otg_csr_pkg::IDX_PORT_CTRL]);
  endfunction

  // Device group
  function automatic logic in_dev_group(input logic [11:0] off);
    return (off >= usb_otg_csr_pkg::DEV_LO) && (off <= usb_otg_csr_pkg::DEV_HI);
  endfunction

  // Write effect by access kind
  function automatic logic [31:0] write_effect(input logic [1:0] acc,
                                               input logic [31:0] old,
                                               input logic [31:0] data);
    logic [31:0] res;
    res = old;
    if (acc == usb_otg_csr_pkg::ACC_RW) begin
      res = data;
    end else if (acc == usb_otg_csr_pkg::ACC_W1C) begin
      res = old & ~data;
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] regs [usb_otg_csr_pkg::NUM_REGS];  // Register storage
  logic [31:0] next_regs [usb_otg_csr_pkg::NUM_REGS];  // Next storage
  usb_otg_csr_pkg::ahb_req_type req;  // Request in data phase
  usb_otg_csr_pkg::ahb_req_type next_req;  // Request being taken
  logic wait_q;  // Write wait state done
  logic id_meta;  // Connector pin, first stage
  logic id_sync;  // Connector pin, second stage
  logic role;  // Present role, 1 is host
  logic first_cycle;  // First clock after reset

  ////////////////////////////////////////////////////////////////////////
  // Connector pin synchroniser
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      id_meta <= 1'b1;
      id_sync <= 1'b1;
    end else begin
      id_meta <= conn_id_in;
      id_sync <= id_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Role selection, forcing bits win over the pin
  wire force_host = regs[usb_otg_csr_pkg::IDX_LINK_CFG][usb_otg_csr_pkg::FORCE_HOST_BIT];
  wire force_dev = regs[usb_otg_csr_pkg::IDX_LINK_CFG][usb_otg_csr_pkg::FORCE_DEV_BIT];
  wire next_role = force_dev ? 1'b0 : (force_host ? 1'b1 : ~id_sync);
  wire role_change = (next_role != role);

  // Role register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      role <= 1'b0;
    end else begin
      role <= next_role;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address phase decode
  // A transfer is taken when selected, ready and active
  wire take = hsel_in & hready_in & htrans_in[1];
  wire [11:0] off = haddr_in[11:0];
  wire reg_area = (haddr_in[ADDR_W-1:usb_otg_csr_pkg::FIFO_SEL_BIT] == '0);
  wire fifo_area = ~reg_area && (haddr_in[ADDR_W-1:usb_otg_csr_pkg::FIFO_SEL_BIT] == 1);
  // Register lookup, index zero on a miss
  wire [6:0] lookup = find_index(off);
  wire hit = reg_area & ~lookup[6];
  wire [5:0] idx = hit ? lookup[5:0] : 6'h00;
  // Mode groups; any access in the inactive one, mapped or not, is a mismatch
  wire host_grp = reg_area & in_host_group(off);
  wire dev_grp = reg_area & in_dev_group(off);
  wire illegal = take & ((role & dev_grp) | (~role & host_grp));  // R5 R8
  // Channel 0 direction gates the FIFO window in host role
  wire ch_in = regs[usb_otg_csr_pkg::IDX_CH0_CHAR][usb_otg_csr_pkg::CH_DIR_IN_BIT];
  wire fifo_rd_ok = ~(role & ~ch_in);  // R7
  wire fifo_wr_ok = ~(role & ch_in);  // R7

  // Decoded request for the data phase
  assign next_req = '{valid: take, write: hwrite_in,
                      word: (hsize_in == usb_otg_csr_pkg::HSIZE_WORD),
                      hit: hit, illegal: illegal,
                      fifo_ok: fifo_area & fifo_wr_ok, idx: idx};

  // FIFO read strobe in the address phase
  assign fifo_rd_out = take & ~hwrite_in & fifo_area & fifo_rd_ok;  // R3 R7

  ////////////////////////////////////////////////////////////////////////
  // Data phase control
  // A write commits in its first data-phase cycle only
  wire commit = req.valid & req.write & ~wait_q;
  // Narrow, unmapped and inactive group writes are dropped
  wire wr_ok = commit & req.word & req.hit & ~req.illegal;  // R2 R11
  wire mismatch = illegal;  // R5

  // One wait state on each write, so a following read sees the new value
  assign hreadyout_out = ~commit;
  assign hresp_out = 1'b0;

  // Request and wait state registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req <= '0;
      wait_q <= 1'b0;
    end else begin
      wait_q <= commit;
      if (hready_in) begin
        req <= next_req;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage, one flop bank per register
  for (genvar gi = 0; gi < usb_otg_csr_pkg::NUM_REGS; gi++) begin : g_reg
    // Offset and group of this register
    localparam logic [11:0] ROFF = usb_otg_csr_pkg::REG_OFFSET[gi];
    localparam bit MODE_REG = (gi != usb_otg_csr_pkg::IDX_PORT_CTRL) &&
      (ROFF >= usb_otg_csr_pkg::HOST_LO) && (ROFF <= usb_otg_csr_pkg::DEV_HI);
    localparam bit IS_STS = (gi == usb_otg_csr_pkg::IDX_INT_STS);
    // Write strobe and the word a write would leave
    wire wr_here = wr_ok && (req.idx == 6'(gi));  // R1
    wire [31:0] written = wr_here ?
      write_effect(usb_otg_csr_pkg::REG_ACCESS[gi], regs[gi], hwdata_in) : regs[gi];
    // Hardware set of the mismatch flag
    wire [31:0] hw_set = (IS_STS && mismatch) ? (32'h1 << usb_otg_csr_pkg::MISMATCH_BIT) :
      32'h0;  // R5

    // Mode registers return to reset values on a role change; set wins over clear
    assign next_regs[gi] = (MODE_REG && role_change) ? usb_otg_csr_pkg::REG_RESET[gi] :
      (written | hw_set);  // R6

    // Storage flops
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
        regs[gi] <= usb_otg_csr_pkg::REG_RESET[gi];  // R12
      end else begin
        regs[gi] <= next_regs[gi];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read value with live status overlays
  wire [31:0] stored = regs[idx];
  wire is_ctrl = (idx == usb_otg_csr_pkg::IDX_OTG_CTRL);
  wire is_sts = (idx == usb_otg_csr_pkg::IDX_INT_STS);
  // Role and synced pin replace the stored bits
  wire [31:0] ctrl_word = (stored & ~((32'h1 << usb_otg_csr_pkg::ROLE_BIT) |
    (32'h1 << usb_otg_csr_pkg::CONN_ID_BIT))) | ({31'h0, role} << usb_otg_csr_pkg::ROLE_BIT) |
    ({31'h0, id_sync} << usb_otg_csr_pkg::CONN_ID_BIT);  // R10
  wire [31:0] sts_word = (stored & ~(32'h1 << usb_otg_csr_pkg::STS_ROLE_BIT)) |
    ({31'h0, role} << usb_otg_csr_pkg::STS_ROLE_BIT);
  wire [31:0] reg_word = is_ctrl ? ctrl_word : (is_sts ? sts_word : stored);
  // Idle cycles, unmapped and inactive offsets read zero
  wire rd_take = take & ~hwrite_in;
  wire [31:0] next_rdata = ~rd_take ? 32'h0 :
    (fifo_rd_out ? fifo_rdata_in : ((hit & ~illegal) ? reg_word : 32'h0));  // R11 R4

  // Read data register and FIFO write port
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0;
      fifo_wr_out <= 1'b0;
      fifo_wdata_out <= 32'h0;
    end else begin
      hrdata_out <= next_rdata;
      fifo_wr_out <= commit & req.word & req.fifo_ok;  // R7
      fifo_wdata_out <= hwdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs
  assign current_role_out = role;  // R10
  assign mode_mismatch_irq_out =
    regs[usb_otg_csr_pkg::IDX_INT_STS][usb_otg_csr_pkg::MISMATCH_BIT] &
    regs[usb_otg_csr_pkg::IDX_INT_MSK][usb_otg_csr_pkg::MISMATCH_BIT] &
    regs[usb_otg_csr_pkg::IDX_BUS_CFG][usb_otg_csr_pkg::GLB_INT_BIT];  // R5
  assign power_clock_gating_out = regs[usb_otg_csr_pkg::IDX_PWR_CLK];  // R9

  ////////////////////////////////////////////////////////////////////////
  // First cycle marker for reset checks
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  wire sts_mm = regs[usb_otg_csr_pkg::IDX_INT_STS][usb_otg_csr_pkg::MISMATCH_BIT];
  wire irq_en = regs[usb_otg_csr_pkg::IDX_INT_MSK][usb_otg_csr_pkg::MISMATCH_BIT] &
    regs[usb_otg_csr_pkg::IDX_BUS_CFG][usb_otg_csr_pkg::GLB_INT_BIT];
  wire port_acc = take & hit & (idx == usb_otg_csr_pkg::IDX_PORT_CTRL);
  wire unmapped_rd = rd_take & reg_area & ~hit;
  wire ctrl_rd = rd_take & hit & is_ctrl;
  wire pwr_wr = wr_ok & (req.idx == usb_otg_csr_pkg::IDX_PWR_CLK);
  // Stored word of the register in the data phase
  wire [31:0] req_word = regs[req.idx];
  // Write to a read-only register
  wire ro_wr = commit & req.hit &
    (usb_otg_csr_pkg::REG_ACCESS[req.idx] == usb_otg_csr_pkg::ACC_RO);
  // Narrow write outside the status register
  wire narrow_wr = commit & ~req.word & req.hit & ~role_change &
    (req.idx != usb_otg_csr_pkg::IDX_INT_STS);
  // Permitted word write into the FIFO window
  wire fifo_commit = commit & req.word & req.fifo_ok;
  // Read of the inactive mode group
  wire bad_rd = rd_take & illegal;

  // Mismatch flag follows an inactive group access
  mismatch_flag_a: assert property (  // R5
    @(posedge sys_clk_in) disable iff (rst_in)
    illegal & ~role_change |=> sts_mm)
    else $error("mismatch flag not set after inactive group access");

  // Enabled mismatch reaches the interrupt line
  mismatch_irq_a: assert property (  // R5
    @(posedge sys_clk_in) disable iff (rst_in)
    illegal & irq_en & ~role_change ##1 irq_en |-> mode_mismatch_irq_out)
    else $error("mismatch interrupt not raised");

  // IN channel window refuses writes
  in_fifo_write_a: assert property (  // R7
    @(posedge sys_clk_in) disable iff (rst_in)
    take & hwrite_in & fifo_area & role & ch_in & hready_in |=> ##1 ~fifo_wr_out)
    else $error("write reached FIFO of an IN channel");

  // OUT channel window refuses reads
  out_fifo_read_a: assert property (  // R7
    @(posedge sys_clk_in) disable iff (rst_in)
    role & ~ch_in |-> ~fifo_rd_out)
    else $error("read reached FIFO of an OUT channel");

  // Unmapped offsets read zero
  unmapped_read_a: assert property (  // R11
    @(posedge sys_clk_in) disable iff (rst_in)
    unmapped_rd |=> (hrdata_out == 32'h0))
    else $error("unmapped read returned nonzero data");

  // Link configuration reset value and zero read data present on the first clock
  reset_value_a: assert property (  // R12
    @(posedge sys_clk_in) disable iff (rst_in)
    first_cycle |-> (regs[usb_otg_csr_pkg::IDX_LINK_CFG] ==
      usb_otg_csr_pkg::REG_RESET[usb_otg_csr_pkg::IDX_LINK_CFG]) && (hrdata_out == 32'h0))
    else $error("register not at reset value after reset");

  // Role bit of the control register
  role_bit_a: assert property (  // R10
    @(posedge sys_clk_in) disable iff (rst_in)
    ctrl_rd |=> (hrdata_out[usb_otg_csr_pkg::ROLE_BIT] == $past(role)))
    else $error("role bit does not show present role");

  // Port register stays reachable in both roles
  common_group_a: assert property (  // R3
    @(posedge sys_clk_in) disable iff (rst_in)
    port_acc |-> ~illegal)
    else $error("port register access flagged as mismatch");

  // Power register takes a word write
  pwr_write_a: assert property (  // R9
    @(posedge sys_clk_in) disable iff (rst_in)
    pwr_wr |=> (power_clock_gating_out == $past(hwdata_in)))
    else $error("power gating register did not take written word");

  // Exactly one wait state per write
  write_wait_a: assert property (  // R1
    @(posedge sys_clk_in) disable iff (rst_in)
    commit |-> ~hreadyout_out ##1 hreadyout_out)
    else $error("write wait state is not exactly one cycle");

  // Read-only registers keep their word under a write
  read_only_a: assert property (  // R1
    @(posedge sys_clk_in) disable iff (rst_in)
    ro_wr |=> $stable(req_word))
    else $error("write changed a read-only register");

  // Byte and halfword writes change nothing
  narrow_write_a: assert property (  // R1
    @(posedge sys_clk_in) disable iff (rst_in)
    narrow_wr |=> $stable(req_word))
    else $error("narrow write changed a register");

  // FIFO write strobe and data one cycle after the commit
  fifo_write_a: assert property (  // R7
    @(posedge sys_clk_in) disable iff (rst_in)
    fifo_commit |=> fifo_wr_out && (fifo_wdata_out == $past(hwdata_in)))
    else $error("FIFO write strobe or data wrong");

  // Inactive group reads return zero
  mismatch_read_a: assert property (  // R5
    @(posedge sys_clk_in) disable iff (rst_in)
    bad_rd |=> (hrdata_out == 32'h0))
    else $error("inactive group read returned data");

  // Role change reloads the channel 0 register
  mode_reload_a: assert property (  // R6
    @(posedge sys_clk_in) disable iff (rst_in)
    role_change |=> (regs[usb_otg_csr_pkg::IDX_CH0_CHAR] ==
      usb_otg_csr_pkg::REG_RESET[usb_otg_csr_pkg::IDX_CH0_CHAR]))
    else $error("channel register not reloaded on role change");

endmodule

`default_nettype wire

/* File: bench/ahb_cpu_model.sv */
// Purpose: AHB-Lite master standing in for the CPU
// Assumes: single slave, ready looped back from the slave
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module ahb_cpu_model (
  input wire logic clk_in,
  input wire logic hready_in,
  output logic hsel_out,
  output logic [12:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  // Idle bus at time zero
  initial begin
    hsel_out = 1'b0;
    haddr_out = 13'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One transfer, address phase then data phase, each held until ready
  task automatic xfer(input logic [12:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] sz);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    hsize_out <= sz;
    @(posedge clk_in);
    while (!hready_in) @(posedge clk_in);
    // Release the address, present data
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    haddr_out <= ~a;
    hwdata_out <= d;
    @(posedge clk_in);
    while (!hready_in) @(posedge clk_in);
    hwdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench of the OTG register bank
// Assumes: one slave, ready looped back, CPU model drives the bus
// Notes: read results are compared in order by a separate monitor
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic conn_id_in = 1'b1;
  logic [31:0] fifo_rdata_in = 32'h0;
  logic hsel, hwrite, hreadyout, hresp, role, irq, fifo_rd, fifo_wr;
  logic [12:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, pgc, fifo_wdata, wd_seen;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic rd_pend = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  int rd_cnt = 0;
  int wr_cnt = 0;

  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;

  usb_otg_csr_map #(.ADDR_W(13)) usb_otg_csr_map_inst (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .conn_id_in(conn_id_in), .current_role_out(role), .mode_mismatch_irq_out(irq),
    .power_clock_gating_out(pgc), .fifo_rd_out(fifo_rd), .fifo_rdata_in(fifo_rdata_in),
    .fifo_wr_out(fifo_wr), .fifo_wdata_out(fifo_wdata));

  ahb_cpu_model cpu (.clk_in(sys_clk_in), .hready_in(hreadyout), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata));

  ////////////////////////////////////////////////////////////////////////
  // Compare one value, count and report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus helpers
  task automatic rd(input logic [12:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    cpu.xfer(a, 1'b0, 32'h0, 3'h2);
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
    cpu.xfer(a, 1'b1, d, sz);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Monitor: read data one cycle after a taken read, FIFO strobes
  always @(posedge sys_clk_in) begin
    if (rd_pend) begin
      check("hrdata", hrdata, exp_q.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    rd_pend = !rst_in && hsel && hreadyout && htrans[1] && !hwrite;
    rd_cnt += int'(fifo_rd);
    wr_cnt += int'(fifo_wr);
    if (fifo_wr) begin
      wd_seen = fifo_wdata;
    end
  end

  // Watchdog, well beyond the few hundred cycles of the tests
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    fails++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [11:0] off;
    logic [31:0] d;
    int n;
    d = $urandom(32'hB597);
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    // Reset values; host group inactive in device role
    for (int i = 0; i < usb_otg_csr_pkg::NUM_REGS; i++) begin
      off = usb_otg_csr_pkg::REG_OFFSET[i];
      d = usb_otg_csr_pkg::REG_RESET[i];
      if (off >= 12'h400 && off <= 12'h7FF && off != 12'h440) d = 32'h0;
      rd({1'b0, off}, d);
    end
    tend("reset");
    // Mismatch flag, interrupt, clear
    rd(13'h014, 32'h04000022);
    wr(13'h008, 32'h00000001);
    wr(13'h018, 32'h00000002);
    check("irq", {31'h0, irq}, 32'h1);
    wr(13'h014, 32'h00000002);
    check("irq", {31'h0, irq}, 32'h0);
    wr(13'h418, $urandom);
    check("irq", {31'h0, irq}, 32'h1);
    rd(13'h418, 32'h0);
    wr(13'h014, 32'h00000002);
    tend("mismatch");
    // Word access, refused byte size, read-only, power register, unmapped
    d = $urandom;
    wr(13'h024, d);
    rd(13'h024, d);
    wr(13'h024, ~d, 3'h0);
    rd(13'h024, d);
    wr(13'h02C, d);
    rd(13'h02C, 32'h00080200);
    wr(13'h020, d);
    rd(13'h020, 32'h0);
    wr(13'h0E00, d);
    check("pgc", pgc, d);
    rd(13'h0E00, d);
    wr(13'h030, d);
    rd(13'h030, 32'h0);
    rd(13'h0F00, 32'h0);
    tend("access");
    // Host role by connector pin
    conn_id_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    check("role", {31'h0, role}, 32'h1);
    rd(13'h000, 32'h00200000);
    rd(13'h014, 32'h04000021);
    rd(13'h808, 32'h0);
    rd(13'h014, 32'h04000023);
    rd(13'h404, 32'h0000EA60);
    // FIFO window with channel 0 OUT, then IN
    wr(13'h500, 32'h0);
    n = rd_cnt;
    rd(13'h1000, 32'h0);
    d = $urandom;
    wr(13'h1000, d);
    @(posedge sys_clk_in);
    check("fifo_rd", rd_cnt, n);
    check("fifo_wr", wr_cnt, 1);
    check("fifo_wdata", wd_seen, d);
    wr(13'h500, 32'h00008000);
    d = $urandom;
    fifo_rdata_in <= d;
    rd(13'h1000, d);
    wr(13'h1000, ~d);
    @(posedge sys_clk_in);
    check("fifo_rd", rd_cnt, n + 1);
    check("fifo_wr", wr_cnt, 1);
    tend("host");
    // Forced device wins, then forced host reloads host group
    wr(13'h00C, 32'h60001400);
    repeat (4) @(posedge sys_clk_in);
    check("role", {31'h0, role}, 32'h0);
    conn_id_in <= 1'b1;
    wr(13'h00C, 32'h20001400);
    repeat (4) @(posedge sys_clk_in);
    check("role", {31'h0, role}, 32'h1);
    rd(13'h500, 32'h0);
    tend("role");
    // Reset in mid-run
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    check("pgc", pgc, 32'h0);
    check("role", {31'h0, role}, 32'h0);
    rd(13'h024, 32'h00000200);
    tend("rereset");
    report_and_stop();
  end
endmodule
`default_nettype wire
